// ==== hdl/dual_axis_torque_off_delay_monitor.v ====
// two-axis torque-off delay monitor with status indicators
//
// Function
// - delay output cut by selected delay
// - codes 0-7 select listed axis delays
// - codes 8-F select listed axis delays
// - selector code fixed at power-up
// - match indicator lit when selectors equal
// - separate indicator set per axis
// - restart indicator lit while contact closed
// - shutdown indicators lit while contact open
// - torque-off indicator lit in torque-off
// - output indicators lit when outputs open
// - fault indicator lit after detected fault
// - open inputs enter torque-off, open outputs
// - release only on restart closed-to-open
// - fault on selector, input, return error
// - both outputs carry the same state
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`include "torque_off_defs.vh"
module dual_axis_torque_off_delay_monitor #(
  parameter [31:0] CYC_1P4  = `T_1P4_MS * `CLK_PER_MS,
  parameter [31:0] CYC_2P8  = `T_2P8_MS * `CLK_PER_MS,
  parameter [31:0] CYC_5P6  = `T_5P6_MS * `CLK_PER_MS,
  parameter [31:0] CYC_9P8  = `T_9P8_MS * `CLK_PER_MS,
  parameter [31:0] CYC_30P8 = `T_30P8_MS * `CLK_PER_MS,
  parameter [31:0] CYC_DISC = `T_DISC_MS * `CLK_PER_MS,
  parameter [31:0] CYC_RET  = `T_RET_MS * `CLK_PER_MS
) (
  input  wire               clk_i,
  input  wire               rst_n_i,
  input  wire [1:0]         shutdown_input_one_i,
  input  wire [1:0]         shutdown_input_two_i,
  input  wire [1:0]         restart_request_input_i,
  input  wire [1:0]         torque_off_state_return_i,
  input  wire [3:0]         delay_selector_first_i,
  input  wire [3:0]         delay_selector_second_i,
  input  wire [`ADDR_W-1:0] address_i,
  input  wire               read_i,
  input  wire               write_i,
  input  wire [31:0]        writedata_i,
  input  wire [3:0]         byteenable_i,
  output wire [31:0]        readdata_o,
  output wire               waitrequest_o,
  output wire [1:0]         safety_output_one_o,
  output wire [1:0]         safety_output_two_o,
  output wire [1:0]         restart_led_o,
  output wire [1:0]         shutdown_one_led_o,
  output wire [1:0]         shutdown_two_led_o,
  output wire [1:0]         torque_off_led_o,
  output wire [1:0]         output_one_led_o,
  output wire [1:0]         output_two_led_o,
  output wire [1:0]         fault_led_o,
  output wire [1:0]         power_led_o,
  output wire               selector_match_led_o
);

  localparam [2:0] ST_INIT  = 3'h0;
  localparam [2:0] ST_RUN   = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_OFF   = 3'h3;
  localparam [2:0] ST_FAULT = 3'h4;

  // delay in cycles for one axis of a selector code
  function [31:0] sel_delay;
    input [3:0] code;
    input       axis_b;
    reg   [2:0] step;
    begin
      step = 3'h0;
      case (code)
        4'h0: step = axis_b ? 3'h0 : 3'h0;
        4'h1: step = axis_b ? 3'h1 : 3'h0;
        4'h2: step = axis_b ? 3'h2 : 3'h0;
        4'h3: step = axis_b ? 3'h4 : 3'h0;
        4'h4: step = axis_b ? 3'h5 : 3'h0;
        4'h5: step = axis_b ? 3'h2 : 3'h1;
        4'h6: step = axis_b ? 3'h4 : 3'h1;
        4'h7: step = axis_b ? 3'h5 : 3'h1;
        4'h8: step = axis_b ? 3'h2 : 3'h2;
        4'h9: step = axis_b ? 3'h4 : 3'h2;
        4'hA: step = axis_b ? 3'h5 : 3'h2;
        4'hB: step = axis_b ? 3'h4 : 3'h3;
        4'hC: step = axis_b ? 3'h5 : 3'h3;
        4'hD: step = axis_b ? 3'h4 : 3'h4;
        4'hE: step = axis_b ? 3'h5 : 3'h4;
        default: step = 3'h5;
      endcase
      case (step)
        3'h1: sel_delay = CYC_1P4;
        3'h2: sel_delay = CYC_2P8;
        3'h3: sel_delay = CYC_5P6;
        3'h4: sel_delay = CYC_9P8;
        3'h5: sel_delay = CYC_30P8;
        default: sel_delay = 32'h0;
      endcase
    end
  endfunction

  // all pin inputs go through two flip-flops
  wire [`SYNC_W-1:0] pins_s;

  pin_sync #(
    .W (`SYNC_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({delay_selector_second_i, delay_selector_first_i,
               torque_off_state_return_i, restart_request_input_i,
               shutdown_input_two_i, shutdown_input_one_i}),
    .sync_o  (pins_s)
  );

  wire [1:0] sd1_s  = pins_s[1:0];
  wire [1:0] sd2_s  = pins_s[3:2];
  wire [1:0] rst_s  = pins_s[5:4];
  wire [1:0] ret_s  = pins_s[7:6];
  wire [3:0] sel1_s = pins_s[11:8];
  wire [3:0] sel2_s = pins_s[15:12];

  // power-up capture of the selector code
  reg [`SETTLE_W-1:0] settle_reg;
  reg                 latched_reg;
  reg [3:0]           code_reg;
  reg                 mismatch_reg;
  reg                 match_led_reg;
  reg                 power_reg;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      settle_reg    <= {`SETTLE_W{1'b0}};
      latched_reg   <= 1'b0;
      code_reg      <= 4'h0;
      mismatch_reg  <= 1'b0;
      match_led_reg <= 1'b0;
      power_reg     <= 1'b0;
    end
    else
    begin
      power_reg <= 1'b1;
      match_led_reg <= (sel1_s == sel2_s);
      if (!latched_reg)
      begin
        if (settle_reg == `SETTLE_CYC)
        begin
          latched_reg  <= 1'b1;
          code_reg     <= sel1_s;
          // unequal selectors count as a fault
          mismatch_reg <= (sel1_s != sel2_s);
        end
        else
        begin
          settle_reg <= settle_reg + {{(`SETTLE_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // software control: per-axis forced stop request
  reg [1:0] force_reg;

  // bus slave: one wait cycle, then the answer
  reg        ack_reg;
  reg [31:0] rdata_reg;
  wire       access = read_i | write_i;
  wire [1:0] toff_w;
  wire [1:0] fault_w;
  wire [1:0] out_w;

  assign waitrequest_o = access & ~ack_reg;
  assign readdata_o    = rdata_reg;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
      force_reg <= `CTL_RESET;
    end
    else
    begin
      ack_reg <= access & ~ack_reg;
      if (read_i && !ack_reg)
      begin
        rdata_reg <= 32'h0;
        case (address_i)
          `OFF_STATUS:
          begin
            rdata_reg[`ST_TOFF_LSB+1:`ST_TOFF_LSB]   <= toff_w;
            rdata_reg[`ST_FAULT_LSB+1:`ST_FAULT_LSB] <= fault_w;
            rdata_reg[`ST_OUT_LSB+1:`ST_OUT_LSB]     <= out_w;
            rdata_reg[`ST_MATCH_BIT]                 <= match_led_reg;
            rdata_reg[`ST_CODE_LSB+3:`ST_CODE_LSB]   <= code_reg;
            rdata_reg[`ST_LATCH_BIT]                 <= latched_reg;
          end
          `OFF_CONTROL:
            rdata_reg[`CTL_FORCE_LSB+1:`CTL_FORCE_LSB] <= force_reg;
          default:
            rdata_reg <= 32'h0;
        endcase
      end
      if (write_i && ack_reg && byteenable_i[0] &&
          address_i == `OFF_CONTROL)
      begin
        force_reg <= writedata_i[`CTL_FORCE_LSB+1:`CTL_FORCE_LSB];
      end
    end
  end

  // per-axis control; axis 0 is the first axis
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : axis
      reg [2:0]  state_reg;
      reg [2:0]  state_next;
      reg [31:0] cnt_reg;
      reg [31:0] cnt_next;
      reg [31:0] disc_reg;
      reg [31:0] ret_reg;
      reg        rst_prev_reg;
      reg        out_reg;
      reg        fault_reg;
      reg [6:0]  led_reg;

      wire [31:0] dly = sel_delay(code_reg, g == 1);
      // any open contact or forced stop demands torque-off
      wire demand = ~sd1_s[g] | ~sd2_s[g] | force_reg[g];
      // release edge is closed-to-open on restart
      wire release_edge = rst_prev_reg & ~rst_s[g];
      // discrepancy between the two shutdown inputs
      wire disc_err = (disc_reg >= CYC_DISC);
      // amplifier return disagrees with our outputs
      wire ret_err = (ret_reg >= CYC_RET);
      wire fault_now = (latched_reg & mismatch_reg) |
                       disc_err | ret_err;
      wire in_off = (state_reg == ST_INIT) ||
                    (state_reg == ST_OFF) ||
                    (state_reg == ST_FAULT);

      always @*
      begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
          ST_INIT:
          begin
            // start in torque-off; a restart is needed to drive
            if (latched_reg)
            begin
              state_next = ST_OFF;
            end
          end
          ST_RUN:
          begin
            if (demand)
            begin
              // hold outputs for the selected delay
              if (dly == 32'h0)
              begin
                state_next = ST_OFF;
              end
              else
              begin
                state_next = ST_DELAY;
                cnt_next   = dly - 32'h1;
              end
            end
          end
          ST_DELAY:
          begin
            // countdown continues even if inputs reclose
            if (cnt_reg == 32'h0)
            begin
              state_next = ST_OFF;
            end
            else
            begin
              cnt_next = cnt_reg - 32'h1;
            end
          end
          ST_OFF:
          begin
            // release only on the restart edge
            if (release_edge && !demand)
            begin
              state_next = ST_RUN;
            end
          end
          ST_FAULT:
            state_next = ST_FAULT;
          default:
            state_next = ST_OFF;
        endcase
        if (fault_now || fault_reg)
        begin
          state_next = ST_FAULT;
        end
      end

      always @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          state_reg    <= ST_INIT;
          cnt_reg      <= 32'h0;
          disc_reg     <= 32'h0;
          ret_reg      <= 32'h0;
          rst_prev_reg <= 1'b0;
          out_reg      <= 1'b0;
          fault_reg    <= 1'b0;
          led_reg      <= 7'h00;
        end
        else
        begin
          state_reg    <= state_next;
          cnt_reg      <= cnt_next;
          rst_prev_reg <= rst_s[g];
          if (sd1_s[g] == sd2_s[g])
          begin
            disc_reg <= 32'h0;
          end
          else if (!disc_err)
          begin
            disc_reg <= disc_reg + 32'h1;
          end
          // return must follow outputs within the window
          if (ret_s[g] == ~out_reg)
          begin
            ret_reg <= 32'h0;
          end
          else if (!ret_err)
          begin
            ret_reg <= ret_reg + 32'h1;
          end
          if (fault_now)
          begin
            fault_reg <= 1'b1;
          end
          out_reg <= (state_next == ST_RUN) ||
                     (state_next == ST_DELAY);
          led_reg[0] <= rst_s[g];
          // shutdown indicators lit on open contact
          led_reg[1] <= ~sd1_s[g];
          led_reg[2] <= ~sd2_s[g];
          led_reg[3] <= in_off;
          led_reg[4] <= ~out_reg;
          led_reg[5] <= ~out_reg;
          led_reg[6] <= fault_reg | fault_now;
        end
      end

      assign safety_output_one_o[g] = out_reg;
      assign safety_output_two_o[g] = out_reg;
      assign restart_led_o[g]       = led_reg[0];
      assign shutdown_one_led_o[g]  = led_reg[1];
      assign shutdown_two_led_o[g]  = led_reg[2];
      assign torque_off_led_o[g]    = led_reg[3];
      assign output_one_led_o[g]    = led_reg[4];
      assign output_two_led_o[g]    = led_reg[5];
      assign fault_led_o[g]         = led_reg[6];
      assign power_led_o[g]         = power_reg;
      assign toff_w[g]              = in_off;
      assign fault_w[g]             = fault_reg;
      assign out_w[g]               = out_reg;
    end
  endgenerate

  assign selector_match_led_o = match_led_reg;

endmodule // dual_axis_torque_off_delay_monitor

// ==== hdl/pin_sync.v ====
// two-stage synchroniser bank for pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] pin_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // first stage feeds the second stage only
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // pin_sync

// ==== include/torque_off_defs.vh ====
// constants for the dual-axis torque-off delay monitor
`ifndef TORQUE_OFF_DEFS_VH
`define TORQUE_OFF_DEFS_VH

// clock rate in cycles per millisecond (40 MHz)
`define CLK_PER_MS     40000

// shutdown delay steps, in milliseconds
`define T_1P4_MS       1400
`define T_2P8_MS       2800
`define T_5P6_MS       5600
`define T_9P8_MS       9800
`define T_30P8_MS      30800

// input discrepancy and return-check windows, in milliseconds
`define T_DISC_MS      100
`define T_RET_MS       10

// settle cycles after reset before the selector code is taken
`define SETTLE_CYC     3'h4
`define SETTLE_W       3

// register byte offsets
`define OFF_STATUS     4'h0
`define OFF_CONTROL    4'h4
`define ADDR_W         4

// status register fields
`define ST_TOFF_LSB    0
`define ST_FAULT_LSB   2
`define ST_OUT_LSB     4
`define ST_MATCH_BIT   6
`define ST_CODE_LSB    8
`define ST_LATCH_BIT   12

// control register fields and reset value
`define CTL_FORCE_LSB  0
`define CTL_RESET      2'h0

// synchroniser width: 4 pairs of axis inputs plus two selectors
`define SYNC_W         16

`endif

// ==== testbench/amp_model.sv ====
// amplifier model returning the torque-off state
`timescale 1ns/10ps
module amp_model (
  input  wire       clk_i,
  input  wire [1:0] out_i,
  input  wire [1:0] break_i,
  output reg  [1:0] ret_o
);
  // one-cycle lag stays well inside the return window
  always @(posedge clk_i)
    ret_o <= ~out_i ^ break_i;
endmodule // amp_model

// ==== testbench/dual_axis_torque_off_delay_monitor_bench.sv ====
// self-checking bench for the torque-off monitor
`timescale 1ns/10ps
module dual_axis_torque_off_delay_monitor_bench;
  localparam [31:0] D1 = 10, D2 = 20, D3 = 40, D4 = 70, D5 = 220;
  localparam [63:0] TA = 64'h5443322211100000;
  localparam [63:0] TB = 64'h5545454254254210;
  reg         clk_i, rst_n_i, rd, wr;
  reg  [1:0]  sd1, sd2, rs, brk;
  reg  [3:0]  s1, s2, addr;
  reg  [31:0] wd, d;
  wire [31:0] rdata;
  wire        wt, ml;
  wire [1:0]  so1, so2, rl, l1, l2, tl, o1, o2, fl, pl, ret;
  integer     n_errors, checks, n, c, ta, tb, base;
  dual_axis_torque_off_delay_monitor #(.CYC_1P4(D1), .CYC_2P8(D2),
    .CYC_5P6(D3), .CYC_9P8(D4), .CYC_30P8(D5), .CYC_DISC(8), .CYC_RET(6))
  u_dual_axis_torque_off_delay_monitor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .shutdown_input_one_i(sd1),
    .shutdown_input_two_i(sd2), .restart_request_input_i(rs),
    .torque_off_state_return_i(ret), .delay_selector_first_i(s1),
    .delay_selector_second_i(s2), .address_i(addr), .read_i(rd),
    .write_i(wr), .writedata_i(wd), .byteenable_i(4'hF),
    .readdata_o(rdata), .waitrequest_o(wt), .safety_output_one_o(so1),
    .safety_output_two_o(so2), .restart_led_o(rl),
    .shutdown_one_led_o(l1), .shutdown_two_led_o(l2),
    .torque_off_led_o(tl), .output_one_led_o(o1), .output_two_led_o(o2),
    .fault_led_o(fl), .power_led_o(pl), .selector_match_led_o(ml));
  amp_model u_amp_model (.clk_i(clk_i), .out_i(so1), .break_i(brk),
    .ret_o(ret));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge clk_i);
  endtask
  // request held until waitrequest is seen low
  task bus(input w, input [3:0] a, input [31:0] v);
    begin
      @(posedge clk_i);
      addr <= a;
      wd <= v;
      rd <= !w;
      wr <= w;
      @(posedge clk_i);
      while (wt !== 1'b0) @(posedge clk_i);
      d = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task boot(input [3:0] a, input [3:0] b);
    begin
      rst_n_i <= 1'b0;
      s1 <= a;
      s2 <= b;
      sd1 <= 2'h3;
      sd2 <= 2'h3;
      rs <= 2'h0;
      brk <= 2'h0;
      cyc(4);
      rst_n_i <= 1'b1;
      cyc(12);
    end
  endtask
  task restart;
    begin
      rs <= 2'h3;
      cyc(4);
      rs <= 2'h0;
      cyc(6);
    end
  endtask
  function [31:0] dly(input [2:0] k);
    dly = (k == 1) ? D1 : (k == 2) ? D2 : (k == 3) ? D3 :
          (k == 4) ? D4 : (k == 5) ? D5 : 0;
  endfunction
  initial
  begin
    #(25 * 40000);
    n_errors = n_errors + 1;
    print_verdict;
  end
  initial
  begin
    n_errors = 0;
    checks = 0;
    {rst_n_i, rd, wr, sd1, sd2, rs, brk, s1, s2, addr, wd} = 0;
    base = 0;
    for (c = 0; c < 16; c = c + 1)
    begin
      boot(c[3:0], c[3:0]);
      check({fl, ml, pl}, 5'h07);
      restart;
      check(so1, 2'h3);
      sd1 <= 2'h0;
      sd2 <= 2'h0;
      ta = -1;
      tb = -1;
      n = 0;
      while (tb < 0 && n < 400)
      begin
        // sampled mid-cycle, away from the launching edge
        @(negedge clk_i);
        n = n + 1;
        if (ta < 0 && so1[0] === 1'b0) ta = n;
        if (tb < 0 && so1[1] === 1'b0) tb = n;
      end
      @(posedge clk_i);
      if (c == 0) base = ta;
      check(ta - base, dly(TA[c*4 +: 3]));
      check(tb - base, dly(TB[c*4 +: 3]));
    end
    cyc(3);
    check({l1, l2, tl, o1, o2}, 10'h3FF);
    s1 <= 4'h3;
    rs <= 2'h3;
    cyc(5);
    check({ml, rl}, 3'h3);
    bus(1'b0, 4'h0, 0);
    check(d[12:8], 5'h1F);
    $display("delay table and indicator test done");
    boot(4'h2, 4'h2);
    restart;
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b0, 4'h4, 0);
    check(d, 32'h1);
    bus(1'b0, 4'h8, 0);
    check(d, 32'h0);
    cyc(4);
    check(so1, 2'h2);
    $display("register test done");
    boot(4'h1, 4'h1);
    restart;
    brk <= 2'h1;
    cyc(14);
    check({fl, so1}, 4'h6);
    restart;
    check(so1, 2'h2);
    bus(1'b0, 4'h0, 0);
    check(d[3:2], 2'h1);
    boot(4'h3, 4'h5);
    check({fl, ml}, 3'h6);
    boot(4'h0, 4'h0);
    sd1 <= 2'h1;
    cyc(16);
    check(fl, 2'h2);
    $display("fault test done");
    print_verdict;
  end
endmodule // dual_axis_torque_off_delay_monitor_bench

// ==== testbench/torque_off_properties.sv ====
// port checker for the dual-axis torque-off monitor
`timescale 1ns/10ps
module torque_off_properties (
  input wire       clk_i,
  input wire       rst_n_i,
  input wire [1:0] shutdown_input_one_i,
  input wire [1:0] restart_request_input_i,
  input wire [3:0] delay_selector_first_i,
  input wire [3:0] delay_selector_second_i,
  input wire       read_i,
  input wire       write_i,
  input wire       waitrequest_o,
  input wire [1:0] safety_output_one_o,
  input wire [1:0] safety_output_two_o,
  input wire [1:0] restart_led_o,
  input wire [1:0] shutdown_one_led_o,
  input wire [1:0] torque_off_led_o,
  input wire [1:0] output_one_led_o,
  input wire [1:0] fault_led_o,
  input wire       selector_match_led_o
);
  reg  [2:0] up_cnt;
  wire       up;
  assign up = (up_cnt == 3'h7);
  // synced history is stale right after reset
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      up_cnt <= 3'h0;
    else if (!up)
      up_cnt <= up_cnt + 3'h1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence req_start;
    (read_i || write_i) && !$past(read_i || write_i);
  endsequence
  sequence one_wait;
    waitrequest_o ##1 !waitrequest_o;
  endsequence
  sequence restart_fall;
    !$past(restart_request_input_i[0], 3) &&
      $past(restart_request_input_i[0], 4);
  endsequence
  AST_OUT_PAIR: assert property (
    safety_output_one_o == safety_output_two_o)
    else $error("safety outputs differ");
  AST_SD_LED: assert property (up |-> shutdown_one_led_o ==
    ~$past(shutdown_input_one_i, 3)) else $error("shutdown led wrong");
  AST_RES_LED: assert property (up |-> restart_led_o ==
    $past(restart_request_input_i, 3)) else $error("restart led wrong");
  AST_OUT_LED: assert property (up |-> output_one_led_o ==
    ~$past(safety_output_one_o)) else $error("output led wrong");
  AST_MATCH_LED: assert property (up |-> selector_match_led_o ==
    ($past(delay_selector_first_i, 3) == $past(delay_selector_second_i, 3)))
    else $error("match led wrong");
  AST_TOFF_LED: assert property (up && $stable(safety_output_one_o) |->
    torque_off_led_o == ~safety_output_one_o) else $error("toff led wrong");
  AST_FAULT_HOLD: assert property (up |->
    (fault_led_o & safety_output_one_o) == 2'h0) else $error("fault not off");
  AST_FAULT_STICKY: assert property (up |->
    ($past(fault_led_o) & ~fault_led_o) == 2'h0) else $error("fault cleared");
  AST_RELEASE: assert property ($rose(safety_output_one_o[0]) |->
    restart_fall) else $error("release without restart edge");
  AST_BUS_WAIT: assert property (req_start |-> one_wait)
    else $error("bus wait not one cycle");
endmodule // torque_off_properties
bind dual_axis_torque_off_delay_monitor torque_off_properties u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i),
  .shutdown_input_one_i(shutdown_input_one_i),
  .restart_request_input_i(restart_request_input_i),
  .delay_selector_first_i(delay_selector_first_i),
  .delay_selector_second_i(delay_selector_second_i),
  .read_i(read_i), .write_i(write_i), .waitrequest_o(waitrequest_o),
  .safety_output_one_o(safety_output_one_o),
  .safety_output_two_o(safety_output_two_o),
  .restart_led_o(restart_led_o), .shutdown_one_led_o(shutdown_one_led_o),
  .torque_off_led_o(torque_off_led_o), .output_one_led_o(output_one_led_o),
  .fault_led_o(fault_led_o), .selector_match_led_o(selector_match_led_o));
